// ---- hdl/atc_arm_ctrl.v ----
`timescale 1ns/1ps
`include "atc_regs.vh"
// Summary of operation
// - Manual arming passes to scan layer only on a step key press.
// - Immediate arming enters the scan layer at once.
// - Bus arming enters scan layer on bus trigger from host.
// - External arming enters scan layer on an external trigger pulse.
// - Step key also arms under bus, external and line arming.
// - Line arming takes one selectable line of six as its source.
// - Input line equal to output line is rejected.
// - Hold never enters the scan layer until another selection replaces it.
// - Arm count 1 to 9999 sets passes through the arm layer.
// - Arm count zero means infinite arming.
// - Source bypass skips the arming wait on first pass, external or line.
// - Acceptor setting waits for the event on every pass.
// - One-closed-relay mode never lets two channels be closed.
// - Multi-channel close keeps only lowest channel in lowest slot.
// - Enabling one-closed-relay mode clears all stored patterns.
// - Enabling that mode is refused while two or more are closed.
// - Restricted channels can never be closed, from panel or bus.
// - Newly restricted channel in scan list or pattern: error 510, clear.
module atc_arm_ctrl #(
    parameter NCH   = 16,
    parameter NPAT  = 4,
    parameter NLINE = 6
) (
    // Clock and reset
    clk,
    rstn,
    // Arm configuration
    arm_src,
    arm_count,
    bypass_en,
    in_line_sel,
    out_line_sel,
    arm_start,
    scan_done,
    // Arming events from outside the clock domain
    step_key,
    bus_trig,
    ext_trig,
    line_trig,
    // Arm status
    scan_start,
    armed_busy,
    line_cfg_err,
    out_line_sel_act,
    in_line_sel_act,
    passes_done,
    // Channel restriction
    one_closed_relay_mode,
    close_req,
    close_strobe,
    open_strobe,
    restrict_list,
    restrict_load,
    scan_list_in,
    scan_list_load,
    pat_in,
    pat_idx,
    pat_store,
    closed_chans,
    scan_list,
    pat_flat,
    mode_refused,
    err_code,
    err_pulse
);
    // Clock and reset
    input  wire              clk;
    input  wire              rstn;
    // Arm configuration
    input  wire [2:0]        arm_src;
    input  wire [13:0]       arm_count;
    input  wire              bypass_en;
    input  wire [2:0]        in_line_sel;
    input  wire [2:0]        out_line_sel;
    input  wire              arm_start;
    input  wire              scan_done;
    // Arming events
    input  wire              step_key;
    input  wire              bus_trig;
    input  wire              ext_trig;
    input  wire [NLINE-1:0]  line_trig;
    // Arm status
    output wire              scan_start;
    output wire              armed_busy;
    output reg               line_cfg_err;
    output reg  [2:0]        out_line_sel_act;
    output reg  [2:0]        in_line_sel_act;
    output reg  [13:0]       passes_done;
    // Channel restriction
    input  wire              one_closed_relay_mode;
    input  wire [NCH-1:0]    close_req;
    input  wire              close_strobe;
    input  wire              open_strobe;
    input  wire [NCH-1:0]    restrict_list;
    input  wire              restrict_load;
    input  wire [NCH-1:0]    scan_list_in;
    input  wire              scan_list_load;
    input  wire [NCH-1:0]    pat_in;
    input  wire [1:0]        pat_idx;
    input  wire              pat_store;
    output reg  [NCH-1:0]    closed_chans;
    output reg  [NCH-1:0]    scan_list;
    output wire [NCH*NPAT-1:0] pat_flat;
    output reg               mode_refused;
    output reg  [9:0]        err_code;
    output reg               err_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers; edges detected only on the second stage
    reg [NLINE+2:0] sync1_reg;
    reg [NLINE+2:0] sync2_reg;
    reg [NLINE+2:0] sync3_reg;
    wire [NLINE+2:0] rise = sync2_reg & ~sync3_reg;

    always @(posedge clk) begin
        if (!rstn) begin
            sync1_reg <= {(NLINE+3){1'b0}};
            sync2_reg <= {(NLINE+3){1'b0}};
            sync3_reg <= {(NLINE+3){1'b0}};
        end else begin
            sync1_reg <= {line_trig, ext_trig, bus_trig, step_key};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    wire step_ev = rise[0];
    wire bus_ev  = rise[1];
    wire ext_ev  = rise[2];
    wire [NLINE-1:0] line_ev = rise[NLINE+2:3];

    ////////////////////////////////////////////////////////////////////////////
    // Trigger line selection; equal in/out lines or out-of-range are refused
    always @(posedge clk) begin
        if (!rstn) begin
            in_line_sel_act  <= `ATC_IN_LINE_RST;
            out_line_sel_act <= `ATC_OUT_LINE_RST;
            line_cfg_err     <= 1'b0;
        end else if (in_line_sel == out_line_sel ||
                     in_line_sel >= NLINE || out_line_sel >= NLINE) begin
            line_cfg_err     <= 1'b1;
        end else begin
            in_line_sel_act  <= in_line_sel;
            out_line_sel_act <= out_line_sel;
            line_cfg_err     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arming event decode for the selected source
    reg arm_ev;
    always @* begin
        case (arm_src)
            `ATC_SRC_MANUAL: arm_ev = step_ev;
            `ATC_SRC_IMMED:  arm_ev = 1'b1;
            `ATC_SRC_BUS:    arm_ev = bus_ev | step_ev;
            `ATC_SRC_EXT:    arm_ev = ext_ev | step_ev;
            `ATC_SRC_LINE:   arm_ev = line_ev[in_line_sel_act] | step_ev;
            default:         arm_ev = 1'b0;
        endcase
    end

    // Bypass only honoured for external and line sources with source setting
    wire bypass_ok = bypass_en &&
                     (arm_src == `ATC_SRC_EXT || arm_src == `ATC_SRC_LINE);

    ////////////////////////////////////////////////////////////////////////////
    // Arm layer state machine
    reg [1:0] state_reg;
    reg       first_reg;
    reg [13:0] count_lat_reg;
    wire go = (state_reg == `ATC_ST_WAIT) &&
              ((first_reg && bypass_ok) || arm_ev);
    assign scan_start = go;
    assign armed_busy = (state_reg != `ATC_ST_IDLE);
    wire last_pass = (count_lat_reg != `ATC_CNT_INFINITE) &&
                     (passes_done + `ATC_CNT_ONE >= count_lat_reg);

    always @(posedge clk) begin
        if (!rstn) begin
            state_reg     <= `ATC_ST_IDLE;
            first_reg     <= 1'b0;
            passes_done   <= 14'h0000;
            count_lat_reg <= `ATC_CNT_ONE;
        end else begin
            case (state_reg)
                `ATC_ST_IDLE: begin
                    if (arm_start) begin
                        state_reg     <= `ATC_ST_WAIT;
                        first_reg     <= 1'b1;
                        passes_done   <= 14'h0000;
                        // Counts above the maximum are clipped
                        count_lat_reg <= (arm_count > `ATC_CNT_MAX) ?
                                         `ATC_CNT_MAX : arm_count;
                    end
                end
                `ATC_ST_WAIT: begin
                    if (go) begin
                        state_reg <= `ATC_ST_SCAN;
                        first_reg <= 1'b0;
                    end
                end
                `ATC_ST_SCAN: begin
                    if (scan_done) begin
                        // Saturate so infinite runs do not wrap
                        if (passes_done != `ATC_CNT_MAX)
                            passes_done <= passes_done + `ATC_CNT_ONE;
                        if (last_pass)
                            state_reg <= `ATC_ST_IDLE;
                        else
                            state_reg <= `ATC_ST_WAIT;
                    end
                end
                default: state_reg <= `ATC_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lowest set bit; channels ordered slot-major so bit 0 is lowest slot
    function [NCH-1:0] lowest_bit;
        input [NCH-1:0] v;
        integer i;
        reg found;
        begin
            lowest_bit = {NCH{1'b0}};
            found = 1'b0;
            for (i = 0; i < NCH; i = i + 1) begin
                if (v[i] && !found) begin
                    lowest_bit[i] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // More than one bit set
    function multi_bit;
        input [NCH-1:0] v;
        begin
            multi_bit = |(v & (v - {{(NCH-1){1'b0}}, 1'b1}));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Channel restriction state
    reg  [NCH-1:0] restrict_reg;
    reg            mode_reg;
    reg  [NCH-1:0] pat_reg [0:NPAT-1];
    wire           mode_en_req = one_closed_relay_mode && !mode_reg;
    wire           mode_ok     = !multi_bit(closed_chans);
    wire [NCH-1:0] allowed     = close_req & ~restrict_reg;
    wire [NCH-1:0] new_restr   = restrict_list & ~restrict_reg;
    reg            scan_hit;
    integer k;

    always @* begin
        scan_hit = restrict_load && |(new_restr & scan_list);
        for (k = 0; k < NPAT; k = k + 1)
            scan_hit = scan_hit | (restrict_load && |(new_restr & pat_reg[k]));
    end

    always @(posedge clk) begin
        if (!rstn) begin
            restrict_reg <= {NCH{1'b0}};
            mode_reg     <= 1'b0;
            mode_refused <= 1'b0;
            closed_chans <= {NCH{1'b0}};
            scan_list    <= {NCH{1'b0}};
            err_code     <= `ATC_ERR_NONE;
            err_pulse    <= 1'b0;
        end else begin
            err_pulse <= scan_hit;
            if (scan_hit)
                err_code <= `ATC_ERR_RESTRICT;
            if (restrict_load)
                restrict_reg <= restrict_list;
            // Mode follows the port, but enabling waits until at most one closed
            if (!one_closed_relay_mode) begin
                mode_reg     <= 1'b0;
                mode_refused <= 1'b0;
            end else if (mode_en_req) begin
                mode_reg     <= mode_ok;
                mode_refused <= !mode_ok;
            end
            if (scan_list_load)
                scan_list <= scan_list_in & ~restrict_reg;
            else if (restrict_load && |(new_restr & scan_list))
                scan_list <= {NCH{1'b0}};
            // Close and open; in the mode the closed set is replaced
            if (open_strobe)
                closed_chans <= closed_chans & ~close_req;
            else if (close_strobe && mode_reg)
                closed_chans <= lowest_bit(allowed);
            else if (close_strobe)
                closed_chans <= closed_chans | allowed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pattern memory, one slot per generate instance
    genvar g;
    generate
        for (g = 0; g < NPAT; g = g + 1) begin : pat_slot
            always @(posedge clk) begin
                if (!rstn)
                    pat_reg[g] <= {NCH{1'b0}};
                else if (mode_en_req && mode_ok)
                    pat_reg[g] <= {NCH{1'b0}};
                else if (restrict_load && |(new_restr & pat_reg[g]))
                    pat_reg[g] <= {NCH{1'b0}};
                else if (pat_store && pat_idx == g)
                    pat_reg[g] <= mode_reg ? lowest_bit(pat_in & ~restrict_reg)
                                           : (pat_in & ~restrict_reg);
            end
            assign pat_flat[g*NCH +: NCH] = pat_reg[g];
        end
    endgenerate

endmodule

// ---- hdl/atc_regs.vh ----
`ifndef ATC_REGS_VH
`define ATC_REGS_VH
// Arming event selections
`define ATC_SRC_MANUAL    3'h0
`define ATC_SRC_IMMED     3'h1
`define ATC_SRC_BUS       3'h2
`define ATC_SRC_EXT       3'h3
`define ATC_SRC_LINE      3'h4
`define ATC_SRC_HOLD      3'h5
// Arm layer states
`define ATC_ST_IDLE       2'h0
`define ATC_ST_WAIT       2'h1
`define ATC_ST_SCAN       2'h2
// Accepted trigger line selections after reset
`define ATC_IN_LINE_RST   3'h0
`define ATC_OUT_LINE_RST  3'h1
// Arm count limits and error code
`define ATC_CNT_INFINITE  14'h0000
`define ATC_CNT_MAX       14'h270F
`define ATC_CNT_ONE       14'h0001
`define ATC_ERR_RESTRICT  10'h1FE
`define ATC_ERR_NONE      10'h000
`endif

// ---- sim/atc_partner.sv ----
`timescale 1ns/1ps
module atc_partner (clk, step_key, bus_trig, ext_trig, line_trig);
    // Clock in, event sources out
    input  wire       clk;
    output reg        step_key;
    output reg        bus_trig;
    output reg        ext_trig;
    output reg  [5:0] line_trig;
    ////////////////////////////////////////////////////////////////
    // Sources rest low between pulses, as the pulled-down inputs do
    initial begin
        {step_key, bus_trig, ext_trig, line_trig} = 9'h000;
    end
    // Four-cycle pulse so the two-stage synchroniser always sees it
    task fire(input integer k, input integer ln, input integer dly);
        repeat (dly) @(negedge clk);
        case (k)
            0: step_key = 1'b1;
            1: bus_trig = 1'b1;
            2: ext_trig = 1'b1;
            default: line_trig[ln] = 1'b1;
        endcase
        repeat (4) @(negedge clk);
        {step_key, bus_trig, ext_trig, line_trig} = 9'h000;
    endtask
endmodule

// ---- sim/atc_arm_ctrl_chk.sv ----
`timescale 1ns/1ps
module atc_chk #(
    parameter NCH = 16
) (clk, rstn, arm_src, arm_count, step_key, scan_done, in_line_sel, out_line_sel,
   one_closed_relay_mode, close_strobe, open_strobe, restrict_list, restrict_load,
   scan_start, armed_busy, line_cfg_err, in_line_sel_act, passes_done, closed_chans,
   scan_list, mode_refused, err_code);
    // Watched ports
    input wire           clk, rstn, step_key, scan_done, one_closed_relay_mode;
    input wire           close_strobe, open_strobe, restrict_load, scan_start;
    input wire           armed_busy, line_cfg_err, mode_refused;
    input wire [2:0]     arm_src, in_line_sel, out_line_sel, in_line_sel_act;
    input wire [13:0]    arm_count, passes_done;
    input wire [NCH-1:0] restrict_list, closed_chans, scan_list;
    input wire [9:0]     err_code;
    // Sample on rising edge, quiet in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // Arm layer
    hold_blocks_a: assert property (
        arm_src >= 3'h5 |-> !scan_start) else $error("scan start while holding");
    immed_arm_a: assert property (
        $rose(armed_busy) && arm_src == 3'h1 |-> ##[0:1] scan_start)
        else $error("immediate arming did not start a scan");
    manual_key_a: assert property (
        scan_start && arm_src == 3'h0 |-> $past(step_key, 2))
        else $error("manual scan start without key");
    infinite_arm_a: assert property (
        arm_count == 14'h0000 && scan_done && armed_busy |=> armed_busy)
        else $error("infinite arming ended");
    count_end_a: assert property (
        $fell(armed_busy) |-> passes_done == arm_count)
        else $error("arming ended at wrong pass count");
    same_line_a: assert property (
        in_line_sel == out_line_sel |=> line_cfg_err && $stable(in_line_sel_act))
        else $error("equal trigger lines accepted");
    ////////////////////////////////////////////////////////////////
    // Channel guard
    one_closed_a: assert property (
        one_closed_relay_mode [*2] ##0 !mode_refused |-> $countones(closed_chans) <= 1)
        else $error("several channels closed in one-relay mode");
    restrict_a: assert property (
        close_strobe && !open_strobe
        |=> (closed_chans & ~$past(closed_chans) & restrict_list) == 0)
        else $error("restricted channel closed");
    restrict_err_a: assert property (
        restrict_load && (restrict_list & scan_list) != 0
        |=> err_code == 10'h1FE && scan_list == 0) else $error("conflict not flagged");
    // Main scenarios reached
    cover property (scan_start && arm_src == 3'h4);
    cover property ($rose(mode_refused));
    cover property ($fell(armed_busy) && passes_done == 14'h0002);
endmodule
bind atc_arm_ctrl atc_chk #(.NCH(NCH)) chk_i (
    .clk(clk), .rstn(rstn), .arm_src(arm_src), .arm_count(arm_count),
    .step_key(step_key), .scan_done(scan_done), .in_line_sel(in_line_sel),
    .out_line_sel(out_line_sel), .one_closed_relay_mode(one_closed_relay_mode),
    .close_strobe(close_strobe), .open_strobe(open_strobe),
    .restrict_list(restrict_list), .restrict_load(restrict_load),
    .scan_start(scan_start), .armed_busy(armed_busy), .line_cfg_err(line_cfg_err),
    .in_line_sel_act(in_line_sel_act), .passes_done(passes_done),
    .closed_chans(closed_chans), .scan_list(scan_list), .mode_refused(mode_refused),
    .err_code(err_code)
);

// ---- sim/atc_arm_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "atc_regs.vh"
module atc_arm_ctrl_tb;
    // Stimulus, all quiet at time zero
    reg         clk = 1'b0, rstn = 1'b0, bypass_en = 1'b0, arm_start = 1'b0;
    reg         scan_done = 1'b0, one_closed_relay_mode = 1'b0, close_strobe = 1'b0;
    reg         open_strobe = 1'b0, restrict_load = 1'b0, scan_list_load = 1'b0;
    reg         pat_store = 1'b0;
    reg  [2:0]  arm_src = 3'h1, in_line_sel = 3'h3, out_line_sel = 3'h1;
    reg  [13:0] arm_count = 14'h0001;
    reg  [15:0] close_req = 16'h0000, restrict_list = 16'h0000;
    reg  [15:0] scan_list_in = 16'h0000, pat_in = 16'h0000;
    reg  [1:0]  pat_idx = 2'h0;
    // Observed outputs
    wire        step_key, bus_trig, ext_trig, scan_start, armed_busy, line_cfg_err;
    wire        mode_refused, err_pulse;
    wire [5:0]  line_trig;
    wire [2:0]  in_line_sel_act, out_line_sel_act;
    wire [13:0] passes_done;
    wire [15:0] closed_chans, scan_list;
    wire [63:0] pat_flat;
    wire [9:0]  err_code;
    integer     bad_count = 0, checks_done = 0;
    // Source table: manual, bus, ext, line, then key under bus, ext, line
    localparam [20:0] src_tab  = 21'h11A8D0;
    localparam [13:0] kind_tab = 14'h00E4;
    always #4 clk = ~clk;
    atc_arm_ctrl DUT (
        .clk(clk), .rstn(rstn), .arm_src(arm_src), .arm_count(arm_count),
        .bypass_en(bypass_en), .in_line_sel(in_line_sel), .out_line_sel(out_line_sel),
        .arm_start(arm_start), .scan_done(scan_done), .step_key(step_key),
        .bus_trig(bus_trig), .ext_trig(ext_trig), .line_trig(line_trig),
        .scan_start(scan_start), .armed_busy(armed_busy), .line_cfg_err(line_cfg_err),
        .out_line_sel_act(out_line_sel_act), .in_line_sel_act(in_line_sel_act),
        .passes_done(passes_done), .one_closed_relay_mode(one_closed_relay_mode),
        .close_req(close_req), .close_strobe(close_strobe), .open_strobe(open_strobe),
        .restrict_list(restrict_list), .restrict_load(restrict_load),
        .scan_list_in(scan_list_in), .scan_list_load(scan_list_load), .pat_in(pat_in),
        .pat_idx(pat_idx), .pat_store(pat_store), .closed_chans(closed_chans),
        .scan_list(scan_list), .pat_flat(pat_flat), .mode_refused(mode_refused),
        .err_code(err_code), .err_pulse(err_pulse)
    );
    atc_partner P (
        .clk(clk), .step_key(step_key), .bus_trig(bus_trig), .ext_trig(ext_trig),
        .line_trig(line_trig)
    );
    ////////////////////////////////////////////////////////////////
    // Shared helpers
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rst;
        @(negedge clk) rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
    endtask
    // Fresh reset per session so pass counts start from zero
    task arm(input logic [2:0] s, input logic [13:0] n);
        rst;
        arm_src = s;
        arm_count = n;
        arm_start = 1'b1;
        @(negedge clk) arm_start = 1'b0;
    endtask
    // Scan start is a one-cycle pulse, so look once per cycle
    task wss(input logic exp, input integer n);
        integer k;
        logic   seen;
        seen = 1'b0;
        for (k = 0; k < n && !seen; k = k + 1) begin
            #1 seen = (scan_start === 1'b1);
            if (!seen) @(negedge clk);
        end
        chk(seen, exp);
        if (seen) begin
            @(negedge clk) scan_done = 1'b1;
            @(negedge clk) scan_done = 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task t_immed;
        arm(`ATC_SRC_IMMED, 14'h0002);
        wss(1'b1, 3);
        wss(1'b1, 6);
        repeat (2) @(negedge clk);
        chk(armed_busy, 1'b0);
        chk(passes_done, 14'h0002);
    endtask
    task t_inf;
        arm(`ATC_SRC_IMMED, `ATC_CNT_INFINITE);
        repeat (3) wss(1'b1, 6);
        chk(armed_busy, 1'b1);
    endtask
    // Unselected line must not arm; then the proper event does
    task t_events;
        integer k;
        for (k = 0; k < 7; k = k + 1) begin
            arm(src_tab[3*k +: 3], `ATC_CNT_ONE);
            fork
                P.fire(3, 0, 0);
                wss(1'b0, 10);
            join
            fork
                P.fire(kind_tab[2*k +: 2], 3, 2);
                wss(1'b1, 12);
            join
        end
    endtask
    task t_lines;
        in_line_sel = 3'h2;
        out_line_sel = 3'h2;
        repeat (2) @(negedge clk);
        chk(line_cfg_err, 1'b1);
        chk({in_line_sel_act, out_line_sel_act}, 6'h19);
        in_line_sel = 3'h4;
        out_line_sel = 3'h5;
        repeat (2) @(negedge clk);
        chk({line_cfg_err, in_line_sel_act, out_line_sel_act}, 7'h25);
    endtask
    task t_hold;
        arm(`ATC_SRC_HOLD, `ATC_CNT_ONE);
        fork
            P.fire(0, 0, 1);
            wss(1'b0, 12);
        join
        arm_src = `ATC_SRC_IMMED;
        wss(1'b1, 4);
    endtask
    task t_bypass;
        bypass_en = 1'b1;
        arm(`ATC_SRC_EXT, 14'h0002);
        wss(1'b1, 4);
        wss(1'b0, 8);
        fork
            P.fire(2, 0, 0);
            wss(1'b1, 10);
        join
        bypass_en = 1'b0;
    endtask
    task t_chan;
        rst;
        scan_list_in = 16'h0006;
        scan_list_load = 1'b1;
        @(negedge clk) scan_list_load = 1'b0;
        restrict_list = 16'h0002;
        restrict_load = 1'b1;
        @(negedge clk) restrict_load = 1'b0;
        chk(err_code, `ATC_ERR_RESTRICT);
        chk(err_pulse, 1'b1);
        chk(scan_list, 16'h0000);
        close_req = 16'h000B;
        close_strobe = 1'b1;
        @(negedge clk) close_strobe = 1'b0;
        chk(closed_chans, 16'h0009);
        one_closed_relay_mode = 1'b1;
        repeat (2) @(negedge clk);
        chk(mode_refused, 1'b1);
        one_closed_relay_mode = 1'b0;
        open_strobe = 1'b1;
        @(negedge clk) open_strobe = 1'b0;
        pat_in = 16'h0030;
        pat_store = 1'b1;
        @(negedge clk) pat_store = 1'b0;
        chk(pat_flat, 64'h30);
        one_closed_relay_mode = 1'b1;
        repeat (2) @(negedge clk);
        chk(mode_refused, 1'b0);
        chk(pat_flat, 64'h0);
        close_req = 16'h00C0;
        close_strobe = 1'b1;
        @(negedge clk) close_strobe = 1'b0;
        chk(closed_chans, 16'h0040);
    endtask
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        bad_count = bad_count + 1;
        wrap_up;
    end
    initial begin
        rst;
        t_immed;
        t_inf;
        t_events;
        t_lines;
        t_hold;
        t_bypass;
        t_chan;
        wrap_up;
    end
endmodule
